// ==== hdl/slot_pkg.sv ====
// Constants, field layouts and types for the conversion slot wrapper.
// Operation
// RULE1: every slot keeps its own trigger, channel and window settings.
// RULE2: slots may share trigger, channel and window freely.
// RULE3: trigger comes from select field plus matching routing register bits.
// RULE4: writing a slot's force bit starts it like a hardware trigger.
// RULE5: six-bit window field gives field plus one converter cycles.
// RULE6: software keeps the window field at six or more.
// RULE7: a fixed thirteen converter cycles of conversion follow each window.
// RULE8: control word packs window, channel, trigger so 4846h means 6,1,9.
// RULE9: trigger code nine is start pulse A of the third modulator.
// RULE10: each result lands in the result register of its own slot.
// RULE11: slots started together convert one after another.
// RULE12: no precharge or discharge of the capacitor before a window.
// RULE13: software enables clock, power and halving bit before use.
// RULE14: four-bit channel; simultaneous mode drops the top bit.
// RULE15: round robin grants the slot above the last; pointer resets to 16.
// RULE16: a trigger during a conversion is held pending, never lost.
package slot_pkg;
   localparam int SLOTS  = 16;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int RES_W  = 12;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [ADDR_W-1:0] SLOT_CTL_BASE  = 6'h00;
   localparam logic [ADDR_W-1:0] RESULT_BASE    = 6'h10;
   localparam logic [ADDR_W-1:0] ROUTE_LOW_ADR  = 6'h20;
   localparam logic [ADDR_W-1:0] ROUTE_HIGH_ADR = 6'h21;
   localparam logic [ADDR_W-1:0] FORCE_ADR      = 6'h22;
   localparam logic [ADDR_W-1:0] CTRL_TWO_ADR   = 6'h23;
   localparam logic [ADDR_W-1:0] SIMULT_ADR     = 6'h24;
   localparam logic [ADDR_W-1:0] PENDING_ADR    = 6'h25;
   localparam logic [ADDR_W-1:0] STATUS_ADR     = 6'h26;
   // ************************************************************
   // Field layout of the slot control word
   // ************************************************************
   localparam int WIN_LSB  = 0;
   localparam int WIN_W    = 6;
   localparam int CH_LSB   = 6;
   localparam int CH_W     = 4;
   localparam int TRIG_LSB = 11;
   localparam int TRIG_W   = 5;
   localparam int ROUTE_W  = 2;
   localparam int CLK_HALF_BIT = 0;
   // ************************************************************
   // Codes, reset values and timing
   // ************************************************************
   localparam logic [TRIG_W-1:0]  TRIG_SOFTWARE  = 5'h00;
   localparam logic [TRIG_W-1:0]  TRIG_PWM3_A    = 5'h09;
   localparam logic [ROUTE_W-1:0] ROUTE_INT_ONE  = 2'h1;
   localparam logic [ROUTE_W-1:0] ROUTE_INT_TWO  = 2'h2;
   localparam logic [4:0]         RR_RESET       = 5'h10;
   localparam logic [WIN_W-1:0]   CONV_CYCLES    = 6'h0d;
   localparam logic [DATA_W-1:0]  CTL_RESET      = 16'h0000;
   localparam logic [ADDR_W-1:0]  ALL_ONES_ADDR  = 6'h3f;
   typedef enum logic [1:0] {
      PH_IDLE    = 2'b00,
      PH_SAMPLE  = 2'b01,
      PH_CONVERT = 2'b11,
      PH_STORE   = 2'b10
   } phase_t;
endpackage

// ==== hdl/clock_divider.sv ====
// Converter clock enable generator with optional halving.
`timescale 1ns/10ps
`default_nettype none
module clock_divider
   import slot_pkg::*;
(
   // Clock and reset.
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Control and enable output.
   input  wire logic halve,
   output logic      tick
);
   typedef struct packed {
      logic phase;
      logic tick;
   } div_t;
   div_t st;
   div_t next_st;
   // Ticks every cycle, or every other cycle when halving.
   always_comb begin
      next_st       = st;
      next_st.phase = halve & ~st.phase;
      next_st.tick  = ~halve | st.phase;
   end
   // State register.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick = st.tick;
endmodule
`default_nettype wire

// ==== hdl/result_memory.sv ====
// Result store, one word per slot, registered read port.
`timescale 1ns/10ps
`default_nettype none
module result_memory
   import slot_pkg::*;
(
   // Clock and reset.
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Write port.
   input  wire logic             wr_en,
   input  wire logic [3:0]       wr_addr,
   input  wire logic [RES_W-1:0] wr_data,
   // Read port.
   input  wire logic             rd_en,
   input  wire logic [3:0]       rd_addr,
   output logic [RES_W-1:0]      rd_data
);
   typedef struct packed {
      logic [SLOTS-1:0][RES_W-1:0] words;
      logic [RES_W-1:0]            rd_data;
   } mem_t;
   mem_t st;
   mem_t next_st;
   // Write the addressed word, latch the read word.
   always_comb begin
      next_st = st;
      if (wr_en) begin
         next_st.words[wr_addr] = wr_data;
      end
      if (rd_en) begin
         next_st.rd_data = st.words[rd_addr];
      end
   end
   // State register.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign rd_data = st.rd_data;
endmodule
`default_nettype wire

// ==== hdl/conversion_slot_config.sv ====
// Sixteen-slot conversion scheduler with register port and core control.
`timescale 1ns/10ps
`default_nettype none
module conversion_slot_config
   import slot_pkg::*;
(
   // Clock and reset.
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   // Register port.
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [DATA_W-1:0]      rd_data,
   // On-chip trigger sources.
   input  wire logic [31:0]       trigger_lines,
   input  wire logic              int_one,
   input  wire logic              int_two,
   // Analog core.
   output logic                   core_tick,
   output logic                   core_sample,
   output logic                   core_convert,
   output logic [CH_W-1:0]        core_channel,
   output logic                   core_simultaneous,
   input  wire logic [RES_W-1:0]  core_result
);

   typedef struct packed {
      logic [SLOTS-1:0][DATA_W-1:0] ctl;
      logic [DATA_W-1:0]            route_low;
      logic [DATA_W-1:0]            route_high;
      logic [SLOTS-1:0]             simult;
      logic [SLOTS-1:0]             pending;
      logic                         clk_half;
      logic [4:0]                   rr_ptr;
      phase_t                       phase;
      logic [3:0]                   slot;
      logic [WIN_W-1:0]             cnt;
      logic [WIN_W-1:0]             win;
      logic [CH_W-1:0]              chan;
      logic                         both;
      logic [DATA_W-1:0]            rd_data;
      logic                         rd_res;
   } state_t;
   state_t           st;
   state_t           next_st;

   logic [SLOTS-1:0] slot_trig;
   logic [SLOTS-1:0] start_mask;
   logic             tick;
   logic [3:0]       grant;
   logic             any_pending;
   logic             store_en;
   logic             res_rd;
   logic [RES_W-1:0] res_data;

   // ************************************************************
   // Converter clock enable
   // ************************************************************
   clock_divider u_div (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .halve   (st.clk_half),
      .tick    (tick)
   );

   // ************************************************************
   // Per-slot trigger selection
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot // RULE2
         logic [ROUTE_W-1:0] route;
         logic [TRIG_W-1:0]  code;
         // Low register routes slots 0-7, high register slots 8-15.
         assign route = (g < 8) ? st.route_low[ROUTE_W*(g%8) +: ROUTE_W]
                                : st.route_high[ROUTE_W*(g%8) +: ROUTE_W]; // RULE3
         assign code  = st.ctl[g][TRIG_LSB +: TRIG_W]; // RULE1
         // Code zero is software only; code nine is modulator three pulse A.
         assign slot_trig[g] = (route == ROUTE_INT_ONE) ? int_one :
                               (route == ROUTE_INT_TWO) ? int_two :
                               ((code != TRIG_SOFTWARE) & trigger_lines[code]); // RULE9
      end
   endgenerate

   // ************************************************************
   // Round robin arbiter
   // ************************************************************
   // Scans from the slot above the last converted one, wrapping at 15.
   always_comb begin
      logic [3:0] base;
      logic [3:0] idx;
      base  = (st.rr_ptr == RR_RESET) ? 4'h0 : 4'(st.rr_ptr + 5'h01); // RULE15
      grant = base;
      idx   = base;
      for (int j = SLOTS - 1; j >= 0; j--) begin
         idx = 4'(base + 4'(j));
         if (st.pending[idx]) begin
            grant = idx;
         end
      end
      any_pending = |st.pending;
   end

   // ************************************************************
   // Register port, pending flags and conversion sequencer
   // ************************************************************
   always_comb begin
      logic [SLOTS-1:0] forced;
      forced     = '0;
      start_mask = '0;
      store_en   = 1'b0;
      next_st    = st;
      res_rd     = rd_en && (addr[ADDR_W-1:4] == RESULT_BASE[ADDR_W-1:4]);

      // Register writes.
      if (wr_en) begin
         if (addr[ADDR_W-1:4] == SLOT_CTL_BASE[ADDR_W-1:4]) begin
            next_st.ctl[addr[3:0]] = wr_data; // RULE8
         end
         case (addr)
            ROUTE_LOW_ADR:  next_st.route_low  = wr_data;
            ROUTE_HIGH_ADR: next_st.route_high = wr_data;
            FORCE_ADR:      forced             = wr_data; // RULE4
            CTRL_TWO_ADR:   next_st.clk_half   = wr_data[CLK_HALF_BIT];
            SIMULT_ADR:     next_st.simult     = wr_data;
            default:        next_st.rd_res     = st.rd_res;
         endcase
      end

      // Register reads; unmapped addresses read zero.
      next_st.rd_res  = res_rd;
      next_st.rd_data = '0;
      if (rd_en) begin
         if (addr[ADDR_W-1:4] == SLOT_CTL_BASE[ADDR_W-1:4]) begin
            next_st.rd_data = st.ctl[addr[3:0]];
         end
         case (addr)
            ROUTE_LOW_ADR:  next_st.rd_data = st.route_low;
            ROUTE_HIGH_ADR: next_st.rd_data = st.route_high;
            CTRL_TWO_ADR:   next_st.rd_data = DATA_W'(st.clk_half);
            SIMULT_ADR:     next_st.rd_data = st.simult;
            PENDING_ADR:    next_st.rd_data = st.pending;
            STATUS_ADR:     next_st.rd_data = {5'h00, st.rr_ptr, st.slot,
                                               st.phase};
            default:        next_st.rd_res  = res_rd;
         endcase
      end

      // Sequencer: one slot at a time from idle through store.
      case (st.phase)
         PH_IDLE: begin
            if (any_pending) begin
               start_mask[grant] = 1'b1; // RULE11
               next_st.slot  = grant;
               next_st.win   = st.ctl[grant][WIN_LSB +: WIN_W]; // RULE5
               next_st.cnt   = st.ctl[grant][WIN_LSB +: WIN_W];
               next_st.both  = st.simult[grant];
               // Simultaneous mode keeps only the pair select bits.
               next_st.chan  = st.simult[grant] ?
                               {1'b0, st.ctl[grant][CH_LSB +: CH_W-1]} :
                               st.ctl[grant][CH_LSB +: CH_W]; // RULE14
               // The window opens at once; no capacitor conditioning phase.
               next_st.phase = PH_SAMPLE; // RULE12
            end
         end

         PH_SAMPLE: begin
            if (tick) begin
               if (st.cnt == '0) begin
                  next_st.cnt   = CONV_CYCLES - 6'h01; // RULE7
                  next_st.phase = PH_CONVERT;
               end else begin
                  next_st.cnt = st.cnt - 6'h01; // RULE5
               end
            end
         end

         PH_CONVERT: begin
            if (tick) begin
               if (st.cnt == '0) begin
                  next_st.phase = PH_STORE;
               end else begin
                  next_st.cnt = st.cnt - 6'h01; // RULE7
               end
            end
         end

         PH_STORE: begin
            store_en       = 1'b1; // RULE10
            next_st.rr_ptr = {1'b0, st.slot}; // RULE15
            next_st.phase  = PH_IDLE;
         end

         default: begin
            next_st.phase = PH_IDLE;
         end
      endcase

      // A new trigger wins over the clear of a started slot.
      next_st.pending = (st.pending & ~start_mask) | slot_trig | forced; // RULE16
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st          <= '0;
         st.ctl      <= {SLOTS{CTL_RESET}};
         st.rr_ptr   <= RR_RESET; // RULE15
         st.phase    <= PH_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Result store
   // ************************************************************
   result_memory u_res (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .wr_en   (store_en),
      .wr_addr (st.slot), // RULE10
      .wr_data (core_result),
      .rd_en   (res_rd),
      .rd_addr (addr[3:0]),
      .rd_data (res_data)
   );

   // Outputs toward software and the core.
   assign rd_data           = st.rd_res ? {4'h0, res_data} : st.rd_data;
   assign core_tick         = tick;
   assign core_sample       = (st.phase == PH_SAMPLE);
   assign core_convert      = (st.phase == PH_CONVERT);
   assign core_channel      = st.chan;
   assign core_simultaneous = st.both;

   // ************************************************************
   // Checks
   // ************************************************************
   logic [WIN_W:0] hcnt;
   // Counts converter ticks spent in the current phase.
   always_ff @(posedge ref_clk) begin
      if (!rst_n || next_st.phase != st.phase) begin
         hcnt <= '0;
      end else begin
         hcnt <= hcnt + 7'(tick);
      end
   end

   // A force sets pending.
   property p_force_pends;
      @(posedge ref_clk) disable iff (!rst_n)
      (wr_en && addr == FORCE_ADR) |=>
         ((st.pending | $past(start_mask)) & $past(wr_data)) == $past(wr_data);
   endproperty
   a_force_pends: assert property (p_force_pends) else $error("force lost"); // RULE4

   // Window is field plus one ticks.
   property p_window_len;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.phase == PH_SAMPLE && next_st.phase == PH_CONVERT) |-> hcnt == 7'(st.win);
   endproperty
   a_window_len: assert property (p_window_len) else $error("window length"); // RULE5

   // Conversion is a fixed length.
   property p_conv_len;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.phase == PH_CONVERT && next_st.phase == PH_STORE) |->
         hcnt == 7'(CONV_CYCLES - 6'h01);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length"); // RULE7

   // Grant is latched as store slot.
   property p_store_slot;
      @(posedge ref_clk) disable iff (!rst_n)
      (|start_mask) |=> st.slot == $past(grant);
   endproperty
   a_store_slot: assert property (p_store_slot) else $error("slot latch"); // RULE10

   // Store moves the pointer.
   property p_store_after;
      @(posedge ref_clk) disable iff (!rst_n)
      store_en |=> st.rr_ptr == {1'b0, $past(st.slot)} && st.phase == PH_IDLE;
   endproperty
   a_store_after: assert property (p_store_after) else $error("pointer"); // RULE15

   // Pointer leaves reset at 16.
   property p_rr_reset;
      @(posedge ref_clk) $rose(rst_n) |-> st.rr_ptr == RR_RESET;
   endproperty
   a_rr_reset: assert property (p_rr_reset) else $error("pointer reset"); // RULE15

   // One start at a time, from idle.
   property p_serial;
      @(posedge ref_clk) disable iff (!rst_n)
      (|start_mask) |-> $onehot(start_mask) && st.phase == PH_IDLE;
   endproperty
   a_serial: assert property (p_serial) else $error("overlap"); // RULE11

   // Pending clears only on start.
   property p_keep_pending;
      @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> (($past(st.pending) & ~$past(start_mask)) & ~st.pending) == '0;
   endproperty
   a_keep_pending: assert property (p_keep_pending) else $error("pending lost"); // RULE16

   // Pair mode drops the top bit.
   property p_pair_chan;
      @(posedge ref_clk) disable iff (!rst_n)
      (core_sample && core_simultaneous) |-> !core_channel[CH_W-1];
   endproperty
   a_pair_chan: assert property (p_pair_chan) else $error("pair channel"); // RULE14

   // Code nine follows pulse A.
   property p_pwm3;
      @(posedge ref_clk) disable iff (!rst_n)
      (trigger_lines[TRIG_PWM3_A] && st.route_low[1:0] == 2'h0
       && st.ctl[0][TRIG_LSB +: TRIG_W] == TRIG_PWM3_A) |=> st.pending[0] || st.slot == 4'h0;
   endproperty
   a_pwm3: assert property (p_pwm3) else $error("trigger nine"); // RULE9

   // Halved ticks never repeat.
   property p_tick_half;
      @(posedge ref_clk) disable iff (!rst_n)
      (st.clk_half && tick) |=> !tick;
   endproperty
   a_tick_half: assert property (p_tick_half) else $error("tick rate"); // RULE13

   // Main scenarios.
   c_store:   cover property (@(posedge ref_clk) disable iff (!rst_n)
      store_en);
   c_shared:  cover property (@(posedge ref_clk) disable iff (!rst_n)
      $countones(slot_trig) > 1);
   c_force:   cover property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en && addr == FORCE_ADR);
   c_wrap:    cover property (@(posedge ref_clk) disable iff (!rst_n)
      store_en && st.slot == 4'hf);
   c_halved:  cover property (@(posedge ref_clk) disable iff (!rst_n)
      store_en && st.clk_half);
endmodule
`default_nettype wire

// ==== tb/core_model.sv ====
// Behavioural model of the analog conversion core seen from the wrapper.
`timescale 1ns/10ps
`default_nettype none
module core_model (
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Core control from the wrapper.
   input  wire logic        core_tick,
   input  wire logic        core_sample,
   input  wire logic        core_convert,
   input  wire logic [3:0]  core_channel,
   input  wire logic        core_simultaneous,
   output logic [11:0]      core_result,
   // Observations for the bench.
   output logic [7:0]       samp_ticks,
   output logic [7:0]       conv_ticks,
   output logic [3:0]       last_ch,
   output logic             last_sim,
   output logic [7:0]       conv_count
);
   logic       samp_d;
   logic       conv_d;
   logic [7:0] s_cnt;
   logic [7:0] c_cnt;
   logic [11:0] res_val;
   // ************************************************************
   // Window and conversion tick counting
   // ************************************************************
   // Ticks are counted per window; no charge is cleared between samples.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         {samp_d, conv_d, s_cnt, c_cnt, samp_ticks, conv_ticks} <= '0;
         {last_ch, last_sim, conv_count, res_val} <= '0;
      end else begin
         samp_d <= core_sample;
         conv_d <= core_convert;
         if (core_sample) s_cnt <= (samp_d ? s_cnt : 8'h00) + {7'h0, core_tick};
         if (core_convert) c_cnt <= (conv_d ? c_cnt : 8'h00) + {7'h0, core_tick};
         if (!core_sample && samp_d) samp_ticks <= s_cnt;
         if (!core_convert && conv_d) conv_ticks <= c_cnt;
         if (core_convert && !conv_d) begin
            res_val    <= {core_channel, conv_count + 8'h01};
            conv_count <= conv_count + 8'h01;
            last_ch    <= core_channel;
            last_sim   <= core_simultaneous;
         end
      end
   end
   // The result is valid from the second conversion cycle through the store cycle only.
   assign core_result = (core_convert || conv_d) ? res_val : ~res_val;
endmodule
`default_nettype wire

// ==== tb/conversion_slot_config_tb_top.sv ====
// Self-checking bench for the conversion slot scheduler.
`timescale 1ns/10ps
`default_nettype none
module conversion_slot_config_tb_top;
   import slot_pkg::*;
   logic              ref_clk;
   logic              rst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data;
   logic              wr_en;
   logic              rd_en;
   logic [DATA_W-1:0] rd_data;
   logic [31:0]       trigger_lines;
   logic              int_one;
   logic              int_two;
   logic              core_tick;
   logic              core_sample;
   logic              core_convert;
   logic [CH_W-1:0]   core_channel;
   logic              core_simultaneous;
   logic [RES_W-1:0]  core_result;
   logic [7:0]        samp_ticks;
   logic [7:0]        conv_ticks;
   logic [3:0]        last_ch;
   logic              last_sim;
   logic [7:0]        conv_count;
   int                err_total;
   int                comparisons;
   int                cycles;
   logic [15:0]       rv;
   conversion_slot_config conversion_slot_config_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .trigger_lines(trigger_lines), .int_one(int_one), .int_two(int_two),
      .core_tick(core_tick), .core_sample(core_sample), .core_convert(core_convert),
      .core_channel(core_channel), .core_simultaneous(core_simultaneous),
      .core_result(core_result));
   core_model core_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .core_tick(core_tick),
      .core_sample(core_sample), .core_convert(core_convert), .core_channel(core_channel),
      .core_simultaneous(core_simultaneous), .core_result(core_result),
      .samp_ticks(samp_ticks), .conv_ticks(conv_ticks), .last_ch(last_ch),
      .last_sim(last_sim), .conv_count(conv_count));
   // ************************************************************
   // Clock, timeout and common tasks
   // ************************************************************
   // The clock toggles every 2.5 ns, a period of 5 ns.
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // A hang is cut short after a generous cycle ceiling.
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         err_total = err_total + 1;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   // Read data are taken in the single cycle after the read edge.
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask
   task automatic wait_conv(input logic [7:0] n);
      int i;
      for (i = 0; i < 600; i++) begin
         @(posedge ref_clk);
         #1;
         if (conv_count === n && !core_convert) break;
      end
      if (i == 600) chk(16'(conv_count), 16'(n), "conversion count");
      repeat (3) @(posedge ref_clk);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      rd(STATUS_ADR, rv);
      chk({11'h0, rv[10:6]}, 16'h0010, "pointer after reset");
      rd(SLOT_CTL_BASE, rv);
      chk(rv, CTL_RESET, "control reset");
      rd(ALL_ONES_ADDR, rv);
      chk(rv, 16'h0000, "unmapped read");
      rd(RESULT_BASE, rv);
      chk(rv, 16'h0000, "result reset");
      wr(SLOT_CTL_BASE, 16'h4846);
      rd(SLOT_CTL_BASE, rv);
      chk(rv, 16'h4846, "control readback");
      $display("test reset done");
   endtask
   task automatic t_force();
      wr(FORCE_ADR, 16'h0001);
      wait_conv(8'h01);
      chk(16'(samp_ticks), 16'h0007, "window ticks");
      chk(16'(conv_ticks), 16'h000d, "conversion ticks");
      chk(16'(last_ch), 16'h0001, "channel field");
      rd(RESULT_BASE, rv);
      chk(rv, 16'h0101, "forced result");
      rd(STATUS_ADR, rv);
      chk({11'h0, rv[10:6]}, 16'h0000, "pointer after slot 0");
      $display("test force done");
   endtask
   // Three slots share code 9; the pointer sits on slot 0, so it goes last.
   task automatic t_pwm_group();
      int s;
      wr(SLOT_CTL_BASE + 6'h01, 16'h4886);
      wr(SLOT_CTL_BASE + 6'h02, 16'h48c6);
      @(posedge ref_clk);
      trigger_lines <= 32'h0000_0208;
      @(posedge ref_clk);
      trigger_lines <= '0;
      wait_conv(8'h04);
      for (s = 0; s < 3; s++) begin
         rd(RESULT_BASE + 6'(s), rv);
         chk(rv, {4'h0, 4'(s + 1), 8'(((s + 2) % 3) + 2)}, "grouped result");
      end
      $display("test pwm group done");
   endtask
   task automatic t_route();
      wr(ROUTE_LOW_ADR, 16'h0400);
      wr(SLOT_CTL_BASE + 6'h05, 16'h0146);
      @(posedge ref_clk);
      int_two <= 1'b1;
      @(posedge ref_clk);
      int_two <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd(PENDING_ADR, rv);
      chk(rv, 16'h0000, "other interrupt ignored");
      @(posedge ref_clk);
      int_one <= 1'b1;
      @(posedge ref_clk);
      int_one <= 1'b0;
      wait_conv(8'h05);
      rd(RESULT_BASE + 6'h05, rv);
      chk(rv, 16'h0505, "routed result");
      $display("test route done");
   endtask
   // Slots 1 and 7 are forced while slot 3 is in its sample window.
   task automatic t_round_robin();
      int i;
      wr(SLOT_CTL_BASE + 6'h01, 16'h0046);
      wr(SLOT_CTL_BASE + 6'h03, 16'h00c6);
      wr(SLOT_CTL_BASE + 6'h07, 16'h01c6);
      wr(FORCE_ADR, 16'h0008);
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         #1;
         if (core_sample) break;
      end
      wr(FORCE_ADR, 16'h0082);
      rd(PENDING_ADR, rv);
      chk(rv, 16'h0082, "held pending");
      wait_conv(8'h08);
      rd(RESULT_BASE + 6'h03, rv);
      chk(rv, 16'h0306, "first served");
      rd(RESULT_BASE + 6'h07, rv);
      chk(rv, 16'h0707, "above pointer served");
      rd(RESULT_BASE + 6'h01, rv);
      chk(rv, 16'h0108, "wrapped slot served");
      rd(STATUS_ADR, rv);
      chk({11'h0, rv[10:6]}, 16'h0001, "pointer after wrap");
      $display("test round robin done");
   endtask
   task automatic t_halved_simult();
      int n;
      wr(CTRL_TWO_ADR, 16'h0001);
      wr(SIMULT_ADR, 16'h0010);
      wr(SLOT_CTL_BASE + 6'h04, 16'h030f);
      n = 0;
      repeat (4) begin
         @(posedge ref_clk);
         #1;
         n = n + int'(core_tick);
      end
      chk(16'(n), 16'h0002, "halved tick rate");
      wr(FORCE_ADR, 16'h0010);
      wait_conv(8'h09);
      chk(16'(samp_ticks), 16'h0010, "window of 16 ticks");
      chk(16'(conv_ticks), 16'h000d, "halved conversion");
      chk(16'(last_ch), 16'h0004, "pair channel");
      chk(16'(last_sim), 16'h0001, "simultaneous flag");
      rd(RESULT_BASE + 6'h04, rv);
      chk(rv, 16'h0409, "simultaneous result");
      $display("test halved simultaneous done");
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   // Reset is held for six cycles, then every scenario runs in turn.
   initial begin
      {err_total, comparisons, cycles} = '0;
      {rst_n, addr, wr_data, wr_en, rd_en, trigger_lines, int_one, int_two} = '0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_force();
      t_pwm_group();
      t_route();
      t_round_robin();
      t_halved_simult();
      give_verdict();
   end
endmodule
`default_nettype wire
